// file: inc/hbis_regs.vh
// Purpose: constants of the host bus interface select block
// Assumes: included by rtl/hbis_host_port.v only
// Notes: definitions only
`ifndef HBIS_REGS_VH
`define HBIS_REGS_VH
// bus style codes, {strap1, strap0}
`define HBIS_STYLE_W16_ONE   2'h0
`define HBIS_STYLE_W16_TWO   2'h1
`define HBIS_STYLE_W16_THREE 2'h2
`define HBIS_STYLE_BYTE8     2'h3
// decoded target kinds
`define HBIS_KIND_BUF  2'h0
`define HBIS_KIND_CMD  2'h1
`define HBIS_KIND_PORT 2'h2
`define HBIS_KIND_NONE 2'h3
// strap capture waits for the pin synchronisers to fill
`define HBIS_STRAP_WAIT 2'h2
// serial frame: header byte, then one 16-bit word
`define HBIS_SER_HDR_BITS 5'h08
`define HBIS_SER_END_BITS 5'h18
// reset values
`define HBIS_RST_WORD 16'h0000
`define HBIS_RST_BUF  32'h00000000
`endif

// file: rtl/hbis_host_port.v
// Purpose: host bus port with strap chosen parallel styles or a 4-wire serial slave
// Assumes: every host pin is asynchronous to i_clk_sys and is synchronised here
// Notes: serial link is mode 0, msb first; SCK is oversampled by the system clock
`timescale 1ns/100ps
`default_nettype none
`include "hbis_regs.vh"

module hbis_host_port (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_cs_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire i_byte_address_lsb,
  input wire [4:1] i_addr,
  input wire [15:0] i_data,
  input wire i_bus_style_strap0,
  input wire i_bus_style_strap1,
  input wire i_device_id_strap0,
  input wire i_device_id_strap1,
  input wire i_interface_busy_n,
  input wire [15:0] i_main_status,
  input wire [7:0] i_sub_status,
  input wire [7:0] i_gpio_in,
  output reg [15:0] o_data,
  output wire o_data_oe_n,
  output wire o_wait_request_out,
  output wire o_wait_request_oe_n,
  output reg o_serial_mode,
  output reg [1:0] o_bus_style,
  output reg [15:0] o_cmd_word,
  output reg [1:0] o_cmd_axis,
  output reg o_cmd_strobe,
  output reg [7:0] o_gpio_out,
  output reg o_gpio_strobe,
  output reg [127:0] o_io_buffers
);

  localparam SYNC_W = 28;

  ////////////////////////////////////////////////////////////////////////////
  // address decode: returns {kind, lane}; lane is a byte lane of the buffer
  function [3:0] map_addr;
    input [1:0] style;
    input a2;
    input a1;
    input a0;
    begin
      case (style)
        `HBIS_STYLE_W16_ONE, `HBIS_STYLE_W16_TWO: begin
          case ({a2, a1})
            2'h0: map_addr = {`HBIS_KIND_BUF, 2'h2};
            2'h1: map_addr = {`HBIS_KIND_BUF, 2'h0};
            2'h2: map_addr = {`HBIS_KIND_PORT, 2'h0};
            default: map_addr = {`HBIS_KIND_CMD, 2'h0};
          endcase
        end
        `HBIS_STYLE_W16_THREE: begin
          case ({a2, a1})
            2'h0: map_addr = {`HBIS_KIND_CMD, 2'h0};
            2'h1: map_addr = {`HBIS_KIND_PORT, 2'h0};
            2'h2: map_addr = {`HBIS_KIND_BUF, 2'h0};
            default: map_addr = {`HBIS_KIND_BUF, 2'h2};
          endcase
        end
        default: begin
          if (a2) begin
            map_addr = {`HBIS_KIND_BUF, a1, a0};
          end else if (a1) begin
            map_addr = {`HBIS_KIND_PORT, 1'b0, a0};
          end else begin
            map_addr = {`HBIS_KIND_CMD, 1'b0, a0};
          end
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for every pin
  reg [SYNC_W-1:0] sync1;
  reg [SYNC_W-1:0] sync2;
  wire [SYNC_W-1:0] pins = {i_cs_n, i_rd_n, i_wr_n, i_byte_address_lsb, i_addr, i_data,
    i_bus_style_strap0, i_bus_style_strap1, i_device_id_strap0, i_device_id_strap1};

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1 <= {3'h7, 25'h0};
      sync2 <= {3'h7, 25'h0};
    end else if (i_ce) begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  wire cs_n = sync2[27];
  wire rd_n = sync2[26];
  wire wr_n = sync2[25];
  wire bal = sync2[24];
  wire [4:1] addr = sync2[23:20];
  wire [15:0] data = sync2[19:4];
  wire strap0 = sync2[3];
  wire strap1 = sync2[2];
  wire [1:0] dev_id = {sync2[0], sync2[1]};

  ////////////////////////////////////////////////////////////////////////////
  // strap capture once after reset release
  reg [1:0] wait_cnt;
  reg straps_taken;

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_cnt <= 2'h0;
      straps_taken <= 1'b0;
      o_serial_mode <= 1'b0;
      o_bus_style <= `HBIS_STYLE_W16_ONE;
    end else if (i_ce && !straps_taken) begin
      if (wait_cnt == `HBIS_STRAP_WAIT) begin
        // held until the next reset; later strap changes are ignored
        straps_taken <= 1'b1;
        o_serial_mode <= !rd_n && !wr_n;
        o_bus_style <= {strap1, strap0};
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end

  wire par_on = straps_taken && !o_serial_mode;
  wire ser_on = straps_taken && o_serial_mode;
  wire style1 = o_bus_style == `HBIS_STYLE_W16_ONE;

  ////////////////////////////////////////////////////////////////////////////
  // parallel strobes; style one uses a direction level and a data strobe
  wire cs_act = par_on && !cs_n;
  wire rd_act = style1 ? (cs_act && !bal && wr_n) : (cs_act && !rd_n);
  wire wr_act = style1 ? (cs_act && !bal && !wr_n) : (cs_act && !wr_n);
  reg wr_act_d;
  // the byte address pin only counts as an address bit in the 8-bit style
  wire a0_eff = (o_bus_style == `HBIS_STYLE_BYTE8) ? bal : 1'b0;
  wire [3:0] par_map = map_addr(o_bus_style, addr[2], addr[1], a0_eff);
  wire [1:0] axis = addr[4:3];

  ////////////////////////////////////////////////////////////////////////////
  // serial slave on oversampled SCK
  reg sck_d;
  reg [4:0] bit_cnt;
  reg [7:0] ser_hdr;
  reg [15:0] ser_shift;
  reg ser_miso;
  wire ss_act = ser_on && !cs_n;
  wire sck_rise = ss_act && strap0 && !sck_d;
  wire sck_fall = ss_act && !strap0 && sck_d;
  // header: id[7:6], read[5], address A4..A0 in [4:0]
  wire id_ok = ser_hdr[7:6] == dev_id;
  wire [3:0] ser_map = map_addr(`HBIS_STYLE_W16_THREE, ser_hdr[2], ser_hdr[1], 1'b0);
  wire ser_wr = sck_rise && id_ok && !ser_hdr[5] && bit_cnt == `HBIS_SER_END_BITS - 5'h01;
  wire [15:0] ser_wdata = {ser_shift[14:0], strap1};

  ////////////////////////////////////////////////////////////////////////////
  // shared write path
  wire do_wr = (wr_act && !wr_act_d) || ser_wr;
  wire [3:0] wmap = ser_wr ? ser_map : par_map;
  wire [1:0] waxis = ser_wr ? ser_hdr[4:3] : axis;
  wire [15:0] wdata = ser_wr ? ser_wdata : data;
  wire wbyte = !ser_wr && o_bus_style == `HBIS_STYLE_BYTE8;

  reg [31:0] io_buf [0:3];
  reg [7:0] axis_sel_byte;
  integer k;
  integer ob;

  always @* begin
    for (ob = 0; ob < 4; ob = ob + 1) begin
      o_io_buffers[ob*32 +: 32] = io_buf[ob];
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_act_d <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        io_buf[k] <= `HBIS_RST_BUF;
      end
      axis_sel_byte <= 8'h00;
      o_cmd_word <= `HBIS_RST_WORD;
      o_cmd_axis <= 2'h0;
      o_cmd_strobe <= 1'b0;
      o_gpio_out <= 8'h00;
      o_gpio_strobe <= 1'b0;
    end else if (i_ce) begin
      wr_act_d <= wr_act;
      o_cmd_strobe <= 1'b0;
      o_gpio_strobe <= 1'b0;
      if (do_wr) begin
        case (wmap[3:2])
          `HBIS_KIND_BUF: begin
            if (wbyte) begin
              io_buf[waxis][wmap[1:0]*8 +: 8] <= wdata[7:0];
            end else begin
              // whole words in the 16-bit styles and for every serial write
              io_buf[waxis][wmap[1]*16 +: 16] <= wdata;
            end
          end
          `HBIS_KIND_CMD: begin
            if (wbyte && wmap[0]) begin
              axis_sel_byte <= wdata[7:0];
            end else begin
              o_cmd_word <= wbyte ? {axis_sel_byte, wdata[7:0]} : wdata;
              o_cmd_axis <= waxis;
              o_cmd_strobe <= 1'b1;
            end
          end
          `HBIS_KIND_PORT: begin
            if (!(wbyte && wmap[0])) begin
              o_gpio_out <= wdata[7:0];
              o_gpio_strobe <= 1'b1;
            end
          end
          default: begin
            o_gpio_strobe <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data selection, shared by both ports
  function [15:0] read_word;
    input [3:0] m;
    input [31:0] b;
    input byte_mode;
    begin
      case (m[3:2])
        `HBIS_KIND_BUF:
          read_word = byte_mode ? {8'h00, b[m[1:0]*8 +: 8]} : b[m[1]*16 +: 16];
        `HBIS_KIND_CMD:
          read_word = byte_mode ? {8'h00, i_main_status[m[0]*8 +: 8]} : i_main_status;
        `HBIS_KIND_PORT:
          read_word = byte_mode ? {8'h00, (m[0] ? i_sub_status : i_gpio_in)}
                                : {i_sub_status, i_gpio_in};
        default: read_word = 16'h0000;
      endcase
    end
  endfunction

  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= `HBIS_RST_WORD;
    end else if (i_ce) begin
      o_data <= read_word(par_map, io_buf[axis], o_bus_style == `HBIS_STYLE_BYTE8);
    end
  end

  // drive the data bus one cycle after the read strobe is seen, so o_data is valid
  reg rd_act_d;
  assign o_data_oe_n = !(rd_act && rd_act_d);
  // word handed to a serial read once the header is complete
  wire [15:0] ser_rword = read_word(ser_map, io_buf[ser_hdr[4:3]], 1'b0);

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine; state restarts whenever slave select rises
  always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_act_d <= 1'b0;
      sck_d <= 1'b0;
      bit_cnt <= 5'h00;
      ser_hdr <= 8'h00;
      ser_shift <= 16'h0000;
      ser_miso <= 1'b1;
    end else if (i_ce) begin
      rd_act_d <= rd_act;
      sck_d <= strap0;
      if (!ss_act) begin
        bit_cnt <= 5'h00;
        ser_miso <= 1'b1;
      end else if (sck_rise) begin
        if (bit_cnt < `HBIS_SER_HDR_BITS) begin
          ser_hdr <= {ser_hdr[6:0], strap1};
        end else if (!ser_hdr[5]) begin
          // a read frame shifts only on the falling edge, else bits are skipped
          ser_shift <= ser_wdata;
        end
        if (bit_cnt != `HBIS_SER_END_BITS) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end else if (sck_fall) begin
        if (bit_cnt == `HBIS_SER_HDR_BITS && ser_hdr[5]) begin
          // load the read word and present its msb
          ser_shift <= ser_rword;
          ser_miso <= ser_rword[15];
        end else if (bit_cnt > `HBIS_SER_HDR_BITS && ser_hdr[5]) begin
          ser_miso <= ser_shift[14];
          ser_shift <= {ser_shift[14:0], 1'b0};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait request pin; in serial mode it is MISO and floats unless addressed,
  // so up to four devices can share the line
  wire ser_drive = ss_act && bit_cnt >= `HBIS_SER_HDR_BITS && id_ok && ser_hdr[5];
  wire ack_n = !(cs_act && !bal && i_interface_busy_n);
  wire wait_n = !(cs_act && !i_interface_busy_n);
  assign o_wait_request_out = ser_on ? ser_miso : (style1 ? ack_n : wait_n);
  assign o_wait_request_oe_n = ser_on ? !ser_drive : !par_on;

endmodule
`default_nettype wire

// file: verif/hbis_host_port_chk.sv
// Purpose: port checker for hbis_host_port
// Assumes: i_ce held high
// Notes: pins reach the logic 2 cycles late
`timescale 1ns/100ps
`default_nettype none
module hbis_host_port_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_byte_address_lsb,
  input wire logic [4:1] i_addr,
  input wire logic [15:0] i_data,
  input wire logic i_bus_style_strap0,
  input wire logic i_bus_style_strap1,
  input wire logic i_interface_busy_n,
  input wire logic o_wait_request_out,
  input wire logic o_wait_request_oe_n,
  input wire logic o_serial_mode,
  input wire logic [1:0] o_bus_style,
  input wire logic [15:0] o_cmd_word,
  input wire logic [1:0] o_cmd_axis,
  input wire logic o_cmd_strobe
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_sys_rst);
  // edges since reset release, saturating; 7 means straps long taken
  logic [2:0] cnt;
  logic par;
  assign par = !o_serial_mode && cnt == 3'h7;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    if (i_sys_rst) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  sequence s_sel;
    !i_cs_n [*3];
  endsequence
  sequence s_lds;
    (!i_cs_n && !i_byte_address_lsb) [*3];
  endsequence
  sequence s_idle;
    i_cs_n [*3];
  endsequence
  a_wait_on_busy: assert property (s_sel ##0 (par && o_bus_style != 2'h0
    && !i_interface_busy_n) |-> !o_wait_request_out) else $error("wait not low");
  a_ack_style_one: assert property (s_lds ##0 (par && o_bus_style == 2'h0
    && i_interface_busy_n) |-> !o_wait_request_out) else $error("no acknowledge");
  a_wait_idle: assert property (s_idle ##0 par
    |-> o_wait_request_out && !o_wait_request_oe_n) else $error("wait pin wrong");
  a_miso_quiet: assert property (s_idle ##0 (o_serial_mode && cnt == 3'h7)
    |-> o_wait_request_oe_n) else $error("serial out driven while deselected");
  a_mode_taken: assert property (cnt == 3'h5 |->
    o_serial_mode == (!$past(i_rd_n, 3) && !$past(i_wr_n, 3)) && (o_serial_mode
    || o_bus_style == {$past(i_bus_style_strap1, 3), $past(i_bus_style_strap0, 3)}))
    else $error("strap capture wrong");
  a_style_held: assert property (cnt == 3'h7
    |-> $stable(o_bus_style) && $stable(o_serial_mode)) else $error("style changed");
  a_cmd_pulse: assert property (o_cmd_strobe |=> !o_cmd_strobe)
    else $error("command strobe too long");
  a_cmd_word: assert property (o_cmd_strobe && !o_serial_mode && o_bus_style != 2'h3
    |-> o_cmd_word == $past(i_data, 3) && o_cmd_axis == $past(i_addr[4:3], 3))
    else $error("command word or axis wrong");
endmodule
bind hbis_host_port hbis_host_port_chk u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr), .i_data(i_data),
  .i_byte_address_lsb(i_byte_address_lsb), .i_interface_busy_n(i_interface_busy_n),
  .i_bus_style_strap0(i_bus_style_strap0), .i_bus_style_strap1(i_bus_style_strap1),
  .o_wait_request_out(o_wait_request_out), .o_wait_request_oe_n(o_wait_request_oe_n),
  .o_serial_mode(o_serial_mode), .o_bus_style(o_bus_style), .o_cmd_word(o_cmd_word),
  .o_cmd_axis(o_cmd_axis), .o_cmd_strobe(o_cmd_strobe));
`default_nettype wire

// file: verif/hbis_host_port_tb.sv
// Purpose: self-checking bench for hbis_host_port
// Assumes: i_ce high, status inputs constant
// Notes: serial mode changes only across resets; straps are inverted after each parallel capture
`timescale 1ns/100ps
`default_nettype none
module hbis_host_port_tb;
  localparam logic [15:0] MS = 16'h5AC3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ser = 1'b0;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic a0 = 1'b0;
  logic busy_n = 1'b1;
  logic s0 = 1'b0;
  logic s1 = 1'b0;
  logic [1:0] id = 2'h2;
  logic [4:1] addr = 4'h0;
  logic [15:0] data = 16'h0000;
  logic [15:0] rdat;
  logic [1:0] st;
  int n_errors = 0;
  int n_tests = 0;
  wire logic [15:0] dout, cw;
  wire logic [127:0] bufs;
  wire logic [7:0] gpo;
  wire logic [1:0] style, cax;
  wire logic doe_n, wq, wq_oe_n, smode, cstb, sck, mosi, ss_n;
  // pull-up on the shared serial data line
  wire logic miso = wq_oe_n ? 1'b1 : wq;
  hbis_host_port u_hbis_host_port (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(1'b1),
    .i_cs_n(ser ? ss_n : cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_byte_address_lsb(a0),
    .i_addr(addr), .i_data(data), .i_bus_style_strap0(ser ? sck : s0),
    .i_bus_style_strap1(ser ? mosi : s1), .i_device_id_strap0(id[0]),
    .i_device_id_strap1(id[1]), .i_interface_busy_n(busy_n), .i_main_status(MS),
    .i_sub_status(8'h00), .i_gpio_in(8'h00), .o_data(dout), .o_data_oe_n(doe_n),
    .o_wait_request_out(wq), .o_wait_request_oe_n(wq_oe_n), .o_serial_mode(smode),
    .o_bus_style(style), .o_cmd_word(cw), .o_cmd_axis(cax), .o_cmd_strobe(cstb),
    .o_gpio_out(gpo), .o_gpio_strobe(), .o_io_buffers(bufs));
  hbis_ser_host u_hbis_ser_host (.i_miso(miso), .o_sck(sck), .o_mosi(mosi), .o_ss_n(ss_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task boot(input logic r, input logic [1:0] sv);
    @(negedge clk);
    rst = 1'b1;
    rd_n = r;
    wr_n = !ser;
    {s1, s0} = sv;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    rd_n = 1'b1;
    wr_n = 1'b1;
  endtask
  // strobe held 4 cycles, then 4 idle cycles before the next command
  task wr(input logic [4:1] ad, input logic b0, input logic [15:0] d);
    cs_n = 1'b0;
    addr = ad;
    a0 = b0;
    data = d;
    wr_n = 1'b0;
    repeat (3) @(negedge clk);
    chk(wq, 1'b0);
    @(negedge clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    a0 = (st == 2'h0);
    repeat (4) @(negedge clk);
  endtask
  task rdw(input logic [4:1] ad);
    cs_n = 1'b0;
    addr = ad;
    rd_n = 1'b0;
    a0 = 1'b0;
    repeat (5) @(negedge clk);
    chk({doe_n, dout}, {1'b0, MS});
    cs_n = 1'b1;
    rd_n = 1'b1;
    a0 = (st == 2'h0);
    repeat (4) @(negedge clk);
  endtask
  initial begin
    for (int s = 0; s < 4; s++) begin
      st = s[1:0];
      busy_n = (st == 2'h0);
      boot(st != 2'h2, st);
      chk({smode, style}, {1'b0, st});
      {s1, s0} = ~st;
      a0 = (st == 2'h0);
      wr({st, st[1], 1'b0}, 1'b0, 16'hA5C3);
      rdat = st[1] ? bufs[st*32 +: 16] : bufs[st*32+16 +: 16];
      chk(rdat, st == 2'h3 ? 16'h00C3 : 16'hA5C3);
      if (st == 2'h3) begin
        wr({st, 2'h0}, 1'b1, 16'h0005);
        wr({st, 2'h0}, 1'b0, 16'h0042);
      end else
        wr({st, (st[1] ? 2'h0 : 2'h3)}, 1'b0, 16'h0542);
      chk({cax, cw}, {st, 16'h0542});
      wr({st, (st[1] ? 2'h1 : 2'h2)}, 1'b0, {8'h00, 6'h25, st});
      chk(gpo, {6'h25, st});
      if (st != 2'h3)
        rdw({st, (st[1] ? 2'h0 : 2'h3)});
      chk(style, st);
    end
    ser = 1'b1;
    boot(1'b0, 2'h0);
    chk(smode, 1'b1);
    u_hbis_ser_host.frame({2'h2, 1'b0, 5'h08, 16'h3C96}, rdat);
    repeat (8) @(negedge clk);
    chk({cax, cw}, {2'h1, 16'h3C96});
    u_hbis_ser_host.frame({2'h1, 1'b0, 5'h08, 16'h1111}, rdat);
    repeat (8) @(negedge clk);
    chk(cw, 16'h3C96);
    u_hbis_ser_host.frame({2'h2, 1'b1, 5'h00, 16'h0000}, rdat);
    chk(rdat, MS);
    stop_test;
  end
  initial begin
    #300000;
    n_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test;
  end
endmodule
`default_nettype wire

// file: verif/hbis_ser_host.sv
// Purpose: serial host master for the hbis serial slave
// Assumes: mode 0, msb first, 160 ns link clock
// Notes: link clock stands low between frames
`timescale 1ns/100ps
`default_nettype none
module hbis_ser_host (
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_ss_n
);
  initial begin
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_ss_n = 1'b1;
  end
  // header {id, read, A4..A0} then one word, on four wires
  task automatic frame(input logic [23:0] bits, output logic [15:0] rdat);
    for (int k = 23; k >= 0; k--) begin
      o_ss_n = 1'b0;
      o_mosi = bits[k];
      #80;
      o_sck = 1'b1;
      rdat = {rdat[14:0], i_miso};
      #80;
      o_sck = 1'b0;
    end
    #80;
    o_ss_n = 1'b1;
    // no pull on this line: show the inverse rather than a stale bit
    o_mosi = ~o_mosi;
  endtask
endmodule
`default_nettype wire
